// *** inc/arb_pkg.sv ***
// Constants for the two-level shared bus arbiter.
// Assumes a single local bus clock domain.
package arb_pkg;
  // Address decoded as the attention request for the HDLC controller
  localparam logic [31:0] ATTN_ADDR_DEFAULT = 32'hFFFF_F000;
  localparam int          ADDR_W_DEFAULT    = 32;
  typedef enum logic [1:0] {
    L1_HOST,
    L1_RELEASE,
    L1_ALT
  } l1_state_t;
  typedef enum logic [1:0] {
    L2_IDLE,
    L2_WAIT,
    L2_HDLC,
    L2_LAN
  } l2_state_t;
endpackage

// *** hdl/bus_arbiter.sv ***
// Two-level arbiter sharing the local bus between host, HDLC and LAN masters.
// Assumes requests come from other boards or chips and are synchronised here.
// Contract
// - Host holds bus whenever no alternate master requests it.
// - Any alternate request raises one request toward first level.
// - First level makes host release, then grants second level.
// - Second level passes grant to the requesting alternate master.
// - Simultaneous requests: HDLC controller wins by fixed priority.
// - Losing LAN request waits until bus returns to the host.
// - LAN hold/hold-acknowledge converted to request/grant handshake.
// - Single host write to defined address yields attention pulse.
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter
  import arb_pkg::*;
#(
  parameter int                  ADDR_W    = ADDR_W_DEFAULT,
  parameter logic [ADDR_W-1:0]   ATTN_ADDR = ATTN_ADDR_DEFAULT[ADDR_W-1:0]
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Host bus grant/busy
  output logic                   host_grant,
  input  wire logic              host_bus_busy,
  // HDLC controller, active-low request/grant style
  input  wire logic              hdlc_req_n,
  output logic                   hdlc_grant_n,
  // LAN controller, active-high hold / hold-acknowledge style
  input  wire logic              lan_hold,
  output logic                   lan_hlda,
  // Host write cycle decode
  input  wire logic              host_ts_n,
  input  wire logic              host_rw_n,
  input  wire logic [ADDR_W-1:0] host_addr,
  output logic                   host_attention_pulse
);
  // ==========================================================
  // Input synchronisers
  // Pin levels, bit 0 upwards: HDLC request, LAN hold, host busy,
  // transfer start and write, all high when active and low at rest
  localparam int PIN_N = 5;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_sync;
  assign pin_raw = {~host_rw_n, ~host_ts_n, host_bus_busy, lan_hold, ~hdlc_req_n};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin_sync
      logic s1_r;
      logic s2_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= 1'h0;
          s2_r <= 1'h0;
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
        end
      end
      assign pin_sync[gi] = s2_r;
    end
  endgenerate

  // Address travels with the write strobe through two stages
  logic [ADDR_W-1:0] addr_s1_r;
  logic [ADDR_W-1:0] addr_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_s1_r <= '0;
      addr_s2_r <= '0;
    end else begin
      addr_s1_r <= host_addr;
      addr_s2_r <= addr_s1_r;
    end
  end

  logic hdlc_req;
  logic lan_req;
  logic host_busy;
  logic ts_act;
  logic wr_act;
  assign hdlc_req  = pin_sync[0];
  assign lan_req   = pin_sync[1];
  assign host_busy = pin_sync[2];
  assign ts_act    = pin_sync[3];
  assign wr_act    = pin_sync[4];

  // ==========================================================
  // Second level arbiter
  // Grant decode shared by both alternate masters
  function automatic logic alt_owner(l1_state_t l1, l2_state_t l2, l2_state_t who);
    return (l1 == L1_ALT) && (l2 == who);
  endfunction

  l2_state_t l2_r;
  logic      alt_req_r;
  logic      alt_grant;
  logic      alt_any;
  assign alt_any = hdlc_req || lan_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l2_r <= L2_IDLE;
    end else begin
      unique case (l2_r)
        // A new round starts only while the host holds the bus, so a
        // losing LAN request waits for the bus to go back to the host
        L2_IDLE: begin
          if (alt_any && host_grant) begin
            l2_r <= L2_WAIT;
          end
        end
        L2_WAIT: begin
          if (alt_grant) begin
            if (hdlc_req) begin
              l2_r <= L2_HDLC;
            end else if (lan_req) begin
              l2_r <= L2_LAN;
            end else begin
              l2_r <= L2_IDLE;
            end
          end
        end
        L2_HDLC: begin
          if (!hdlc_req) begin
            l2_r <= L2_IDLE;
          end
        end
        L2_LAN: begin
          if (!lan_req) begin
            l2_r <= L2_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_req_r <= 1'h0;
    end else begin
      alt_req_r <= (l2_r != L2_IDLE);
    end
  end

  // ==========================================================
  // First level arbiter
  l1_state_t l1_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l1_r <= L1_HOST;
    end else begin
      unique case (l1_r)
        L1_HOST: begin
          if (alt_req_r) begin
            l1_r <= L1_RELEASE;
          end
        end
        // Wait for the host to finish its cycle before handing over
        L1_RELEASE: begin
          if (!host_busy) begin
            l1_r <= L1_ALT;
          end
        end
        L1_ALT: begin
          if (!alt_req_r) begin
            l1_r <= L1_HOST;
          end
        end
        default: begin
          l1_r <= L1_HOST;
        end
      endcase
    end
  end

  assign alt_grant = (l1_r == L1_ALT);

  // ==========================================================
  // Grant outputs
  // Host grant drops as soon as an alternate request is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_grant <= 1'h1;
    end else begin
      host_grant <= (l1_r == L1_HOST) && !alt_req_r;
    end
  end

  // Alternate grants only once the first level has handed the bus over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_grant_n <= 1'h1;
    end else begin
      hdlc_grant_n <= !alt_owner(l1_r, l2_r, L2_HDLC);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lan_hlda <= 1'h0;
    end else begin
      lan_hlda <= alt_owner(l1_r, l2_r, L2_LAN);
    end
  end

  // ==========================================================
  // Attention pulse decode
  logic ts_d_r;
  logic ts_start;
  logic attn_hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_d_r <= 1'h0;
    end else begin
      ts_d_r <= ts_act;
    end
  end

  // One pulse per transfer start, however long the strobe stays low
  assign ts_start = ts_act && !ts_d_r;
  assign attn_hit = ts_start && wr_act && (addr_s2_r == ATTN_ADDR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_attention_pulse <= 1'h0;
    end else begin
      host_attention_pulse <= attn_hit;
    end
  end
endmodule
`default_nettype wire

// *** dv/arb_checker.sv ***
// Port checker for bus_arbiter
// Assumes a bind onto bus_arbiter
`timescale 1ns/1ps
`default_nettype none
module arb_checker #(
  parameter int                ADDR_W    = 32,
  parameter logic [ADDR_W-1:0] ATTN_ADDR = '0
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              host_grant,
  input wire logic              hdlc_req_n,
  input wire logic              hdlc_grant_n,
  input wire logic              lan_hold,
  input wire logic              lan_hlda,
  input wire logic              host_ts_n,
  input wire logic              host_rw_n,
  input wire logic              host_attention_pulse,
  input wire logic [ADDR_W-1:0] host_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  one_owner_a: assert property (!host_grant || hdlc_grant_n && !lan_hlda)
    else $error("two owners");
  alt_excl_a: assert property (hdlc_grant_n || !lan_hlda) else $error("two alts");
  host_default_a: assert property ((hdlc_req_n && !lan_hold) [*8] |-> ##[0:8] host_grant)
    else $error("no host");
  host_release_a: assert property (host_grant && !hdlc_req_n |-> ##[1:20] !host_grant)
    else $error("no release");
  alt_grant_a: assert property ($fell(host_grant) |-> ##[1:12] (!hdlc_grant_n || lan_hlda))
    else $error("no alt");
  lan_cause_a: assert property ($rose(lan_hlda) |-> $past(lan_hold, 2)) else $error("lan");
  hdlc_back_a: assert property ($rose(hdlc_grant_n) |-> ##[1:8] host_grant)
    else $error("no return");
  attn_pulse_a: assert property ($fell(host_ts_n) && !host_rw_n && host_addr == ATTN_ADDR
    |-> ##[1:4] host_attention_pulse) else $error("no pulse");
endmodule
bind bus_arbiter arb_checker #(
  .ADDR_W    (ADDR_W),
  .ATTN_ADDR (ATTN_ADDR)
) u_arb_checker (
  .clk                  (clk),
  .rst_n                (rst_n),
  .host_grant           (host_grant),
  .hdlc_req_n           (hdlc_req_n),
  .hdlc_grant_n         (hdlc_grant_n),
  .lan_hold             (lan_hold),
  .lan_hlda             (lan_hlda),
  .host_ts_n            (host_ts_n),
  .host_rw_n            (host_rw_n),
  .host_attention_pulse (host_attention_pulse),
  .host_addr            (host_addr)
);
`default_nettype wire

// *** dv/host_model.sv ***
// Host model: busy now and then while granted
// Assumes the arbiter clock and reset
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic host_grant,
  output logic      host_bus_busy
);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) host_bus_busy <= 1'b0;
    else host_bus_busy <= host_grant && $urandom_range(1);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Random bench for bus_arbiter
// Assumes arb_pkg, host_model and the checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import arb_pkg::*;
  logic clk = 0, rst_n = 0, hdlc_req_n = 1, lan_hold = 0, host_ts_n = 1, host_rw_n = 1;
  logic [31:0] host_addr = '0;
  wire host_grant, host_bus_busy, hdlc_grant_n, lan_hlda, host_attention_pulse;
  int failures = 0, check_count = 0, k, n, sh;
  always #12.5 clk = ~clk;
  bus_arbiter u_bus_arbiter (
    .clk                  (clk),
    .rst_n                (rst_n),
    .host_grant           (host_grant),
    .host_bus_busy        (host_bus_busy),
    .hdlc_req_n           (hdlc_req_n),
    .hdlc_grant_n         (hdlc_grant_n),
    .lan_hold             (lan_hold),
    .lan_hlda             (lan_hlda),
    .host_ts_n            (host_ts_n),
    .host_rw_n            (host_rw_n),
    .host_addr            (host_addr),
    .host_attention_pulse (host_attention_pulse)
  );
  host_model u_host_model (
    .clk           (clk),
    .rst_n         (rst_n),
    .host_grant    (host_grant),
    .host_bus_busy (host_bus_busy)
  );
  task automatic chk(logic s, logic e);
    check_count++;
    if (s !== e) begin failures++; $display("Error %0t mismatch", $time); end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wt(int s);
    sh = 0;
    for (int t = 0; t < 60; t++) begin
      if (s == 0 ? !hdlc_grant_n || lan_hlda : s == 1 ? lan_hlda : host_grant) break;
      sh |= host_grant;
      @(negedge clk);
    end
  endtask
  function automatic logic ex(logic rw, logic [31:0] a); return !rw && a == ATTN_ADDR_DEFAULT;
  endfunction
  task automatic attn(logic rw, logic [31:0] a);
    host_rw_n = rw; host_addr = a; host_ts_n = 0; n = 0;
    @(negedge clk) host_ts_n = 1;
    repeat (6) @(negedge clk) n += host_attention_pulse;
    chk(n == (ex(rw, a) ? 1 : 0), 1'b1);
    if (ex(rw, a)) begin
      hdlc_req_n = 0;
      wt(0);
      chk(hdlc_grant_n, 1'b0);
      hdlc_req_n = 1;
      wt(2);
      chk(host_grant, 1'b1);
    end
    $display("attention test done");
  endtask
  initial begin
    void'($urandom(65));
    repeat (20) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk(host_grant && hdlc_grant_n && !lan_hlda, 1'b1);
    for (int i = 0; i < 9; i++) begin
      k = i < 3 ? i : $urandom_range(2);
      hdlc_req_n = k == 1; lan_hold = k != 0;
      wt(0);
      chk(hdlc_grant_n, k == 1);
      chk(lan_hlda, k == 1);
      chk(host_grant, 1'b0);
      repeat ($urandom_range(4)) @(negedge clk);
      hdlc_req_n = 1;
      if (k == 2) begin wt(1); chk(sh && lan_hlda, 1'b1); end
      lan_hold = 0;
      wt(2);
      chk(host_grant, 1'b1);
      $display("test %0d done", i);
    end
    attn(0, ATTN_ADDR_DEFAULT); attn(1, ATTN_ADDR_DEFAULT); attn(0, $urandom);
    final_report();
  end
  initial begin #100us; failures++; final_report(); end
endmodule
`default_nettype wire
